// [pkg/adccal_pkg.sv]
// package for the calibration control register block
// assumes an 8-bit special-function-register port on the core clock
package adccal_pkg;
  localparam logic [7:0] ADCCAL_ADDR       = 8'hF5;
  localparam logic [7:0] ADCCAL_RESET      = 8'h00;
  localparam int         ADCCAL_BUSY_BIT   = 7;
  localparam int         ADCCAL_SPARE6_BIT = 6;
  localparam int         ADCCAL_AVG_HI_BIT = 5;
  localparam int         ADCCAL_AVG_LO_BIT = 4;
  localparam int         ADCCAL_SPARE3_BIT = 3;
  localparam int         ADCCAL_CALKEY_BIT = 2;
  localparam int         ADCCAL_TYPE_BIT   = 1;
  localparam int         ADCCAL_START_BIT  = 0;
  localparam logic [5:0] ADCCAL_AVG_00     = 6'h0F;
  localparam logic [5:0] ADCCAL_AVG_01     = 6'h01;
  localparam logic [5:0] ADCCAL_AVG_10     = 6'h1F;
  localparam logic [5:0] ADCCAL_AVG_11     = 6'h3F;

  typedef enum logic [1:0] {
    ADCCAL_IDLE  = 2'b00,
    ADCCAL_REQ   = 2'b01,
    ADCCAL_RUN   = 2'b10
  } adccal_state_e;

  // code of the averaging field to number of readings
  function automatic logic [5:0] adccal_avg_count(input logic [1:0] code);
    unique case (code)
      2'b00: adccal_avg_count = ADCCAL_AVG_00;
      2'b01: adccal_avg_count = ADCCAL_AVG_01;
      2'b10: adccal_avg_count = ADCCAL_AVG_10;
      2'b11: adccal_avg_count = ADCCAL_AVG_11;
    endcase
  endfunction
endpackage

// [pkg/adccal_if.sv]
// interface from the register to the calibration sequencer
// assumes both ends run on the core clock
interface adccal_if;
  logic       start;
  logic       cal_type;
  logic [5:0] avg_count;
  logic       running;
  logic       done;
  modport reg_side (output start, output cal_type, output avg_count,
                    input running, input done);
  modport seq_side (input start, input cal_type, input avg_count,
                    output running, output done);
endinterface

// [hdl/adccal_seq.sv]
// calibration handshake toward the converter engine
// assumes the engine acks a request with i_eng_done one pulse at the end
module adccal_seq
  import adccal_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst,
  adccal_if.seq_side   cal,
  // engine side
  output logic        o_eng_req,
  input  wire logic   i_eng_done
);
  typedef struct packed {
    adccal_state_e state;
  } adccal_seq_s;

  adccal_seq_s r;
  adccal_seq_s next_r;

  always_comb begin
    next_r = r;
    unique case (r.state)
      ADCCAL_IDLE: if (cal.start) next_r.state = ADCCAL_REQ;
      ADCCAL_REQ:  next_r.state = ADCCAL_RUN;
      ADCCAL_RUN:  if (i_eng_done) next_r.state = ADCCAL_IDLE;
      default:     next_r.state = ADCCAL_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) r <= '{state: ADCCAL_IDLE};
    else r <= next_r;
  end

  assign o_eng_req   = (r.state == ADCCAL_REQ);
  assign cal.running = (r.state != ADCCAL_IDLE);
  assign cal.done    = (r.state == ADCCAL_RUN) && i_eng_done;
endmodule

// [hdl/adccal_ctrl.sv]
// calibration control and busy status register of the converter
// assumes a core register port: write/read strobes with an 8-bit address
module adccal_ctrl
  import adccal_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // converter engine
  input  wire logic       i_conv_busy,
  input  wire logic       i_cal_done,
  output logic            o_cal_req,
  output logic            o_cal_gain,
  output logic      [5:0] o_cal_avg
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] avg;
    logic       cal_key;
    logic       cal_type;
    logic       start;
    logic       busy;
    logic       req;
    logic       gain;
    logic [5:0] avg_n;
  } adccal_ctrl_s;

  adccal_ctrl_s r;
  adccal_ctrl_s next_r;
  adccal_if     cal();
  logic         eng_req;
  logic         hit_wr;
  logic         kick;

  adccal_seq u_seq (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .cal        (cal.seq_side),
    .o_eng_req  (eng_req),
    .i_eng_done (i_cal_done)
  );

  // one decode for both strobes keeps read and write on the same address
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr);
    return strobe && (addr == ADCCAL_ADDR);
  endfunction

  assign hit_wr        = reg_hit(i_wr, i_addr);
  // new start only from idle; a write during a run cannot restart it
  assign kick          = hit_wr && i_wdata[ADCCAL_START_BIT] && !r.start && !cal.running;
  assign cal.start     = kick;
  assign cal.cal_type  = r.cal_type;
  assign cal.avg_count = r.avg_n;

  always_comb begin
    next_r = r;
    if (hit_wr) begin
      // bits 6 and 3 are reserved and never stored
      next_r.avg      = i_wdata[ADCCAL_AVG_HI_BIT:ADCCAL_AVG_LO_BIT];
      next_r.cal_key  = i_wdata[ADCCAL_CALKEY_BIT];
      next_r.cal_type = i_wdata[ADCCAL_TYPE_BIT];
    end
    if (kick) begin
      next_r.start = 1'b1;
      next_r.gain  = i_wdata[ADCCAL_TYPE_BIT];
      next_r.avg_n = adccal_avg_count(i_wdata[ADCCAL_AVG_HI_BIT:ADCCAL_AVG_LO_BIT]);
    end
    if (cal.done) next_r.start = 1'b0;
    next_r.req  = eng_req;
    // busy follows engine and calibration; write to bit 7 ignored
    next_r.busy = i_conv_busy || next_r.start;
    if (reg_hit(i_rd, i_addr))
      next_r.rdata = {r.busy, 1'b0, r.avg, 1'b0, r.cal_key, r.cal_type, r.start};
    else
      next_r.rdata = 8'h00;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata    = r.rdata;
  assign o_cal_req  = r.req;
  assign o_cal_gain = r.gain;
  assign o_cal_avg  = r.avg_n;
endmodule

// [test/adccal_chk.sv]
// port checker for the calibration control register
// assumes binding onto adccal_ctrl
module adccal_chk
  import adccal_pkg::*;
(
  input wire logic       i_mclk, i_rst, i_wr, i_rd, i_conv_busy, i_cal_done,
  input wire logic       o_cal_req, o_cal_gain,
  input wire logic [7:0] i_addr, i_wdata, o_rdata,
  input wire logic [5:0] o_cal_avg
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] AVG [4] = '{ADCCAL_AVG_00, ADCCAL_AVG_01, ADCCAL_AVG_10, ADCCAL_AVG_11};
  logic                  st, rd, go;
  assign rd = i_rd && i_addr == ADCCAL_ADDR;
  assign go = i_wr && i_addr == ADCCAL_ADDR && i_wdata[0] && !st;
  // shadow start bit; a start during a run is dropped
  always_ff @(posedge i_mclk) st <= !i_rst && (go || (st && !i_cal_done));
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_req_after_start: assert property (go |-> ##2 o_cal_req) else $error("no req");
  a_req_one_cycle: assert property (o_cal_req |=> !o_cal_req) else $error("long req");
  a_gain_latched: assert property (o_cal_req |-> o_cal_gain == $past(i_wdata[1], 2))
    else $error("bad type");
  a_avg_decoded: assert property (o_cal_req |-> o_cal_avg == AVG[$past(i_wdata[5:4], 2)])
    else $error("bad avg");
  a_busy_conv: assert property (rd && $past(i_conv_busy) && !$past(i_rst) |=> o_rdata[7])
    else $error("no busy");
  a_busy_during_cal: assert property (
    rd && st && $past(st) |=> o_rdata[7] && o_rdata[0]) else $error("no cal busy");
  a_idle_clear: assert property (
    rd && !st && !$past(st) && !$past(i_conv_busy) |=> !o_rdata[7] && !o_rdata[0])
    else $error("stuck busy");
  a_reset_zero: assert property (
    disable iff (1'b0) i_rst |=> o_rdata == 8'h00 && !o_cal_req && !o_cal_gain
    && o_cal_avg == 6'h00) else $error("bad reset");
  cover property (o_cal_req && o_cal_gain);
  cover property (rd && i_conv_busy);
  cover property (i_cal_done && st);
  cover property (i_wr && i_addr == ADCCAL_ADDR && i_wdata[0] && st);
endmodule
bind adccal_ctrl adccal_chk i_adccal_chk (
  .i_mclk      (i_mclk),
  .i_rst       (i_rst),
  .i_wr        (i_wr),
  .i_rd        (i_rd),
  .i_conv_busy (i_conv_busy),
  .i_cal_done  (i_cal_done),
  .o_cal_req   (o_cal_req),
  .o_cal_gain  (o_cal_gain),
  .i_addr      (i_addr),
  .i_wdata     (i_wdata),
  .o_rdata     (o_rdata),
  .o_cal_avg   (o_cal_avg)
);

// [test/adccal_ctrl_tb_top.sv]
// self-checking bench for the calibration control register
// assumes the bench plays core and converter engine
module adccal_ctrl_tb_top
  import adccal_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
  logic       i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_conv_busy = 0, i_cal_done = 0;
  logic [7:0] i_addr = ADCCAL_ADDR, i_wdata = 8'h00, o_rdata, d, m;
  logic       o_cal_req, o_cal_gain, g = 1'b0;
  logic [5:0] o_cal_avg, a = 6'h00;
  int         seed = 11928, err_total = 0, checks = 0;
  adccal_ctrl i_adccal_ctrl (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_addr      (i_addr),
    .i_wr        (i_wr),
    .i_rd        (i_rd),
    .i_wdata     (i_wdata),
    .o_rdata     (o_rdata),
    .i_conv_busy (i_conv_busy),
    .i_cal_done  (i_cal_done),
    .o_cal_req   (o_cal_req),
    .o_cal_gain  (o_cal_gain),
    .o_cal_avg   (o_cal_avg)
  );
  initial forever #5 i_mclk = ~i_mclk;
  function automatic logic [5:0] avg_of(input logic [1:0] c);
    return c == 2'b01 ? 6'h01 : {c == 2'b11, c[1], 4'hF};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] v);
    i_wdata = v;
    i_wr = 1;
    tick(1);
    i_wr = 0;
  endtask
  task automatic rd(input logic [7:0] e);
    i_rd = 1;
    tick(1);
    i_rd = 0;
    `CHK("rdata", e, o_rdata)
  endtask
  task automatic finish_test;
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(8);
    i_rst = 0;
    rd(8'h00);
    for (int k = 0; k < 12; k++) begin
      d = 8'($random(seed));
      // corner codes and types first, then random writes without start
      d = k < 8 ? {d[7], 1'b0, k[1:0], 1'b0, 1'b1, k[2], 1'b1} : d & 8'hB6;
      wr(d);
      m = d & 8'h36;
      if (d[0]) begin
        `CHK("req_early", 1'b0, o_cal_req)
        tick(1);
        g = d[1];
        a = avg_of(d[5:4]);
        `CHK("req", 1'b1, o_cal_req)
        if (k == 3) begin
          // start written again mid-run: fields move, the run does not
          wr(d ^ 8'h32);
          m = (d ^ 8'h32) & 8'h36;
          `CHK("req_once", 1'b0, o_cal_req)
        end
        `CHK("gain", g, o_cal_gain)
        `CHK("avg", a, o_cal_avg)
        rd(m | 8'h81);
        i_cal_done = 1;
        tick(1);
        i_cal_done = 0;
        tick(1);
      end
      rd(m);
      `CHK("gain_hold", g, o_cal_gain)
      `CHK("avg_hold", a, o_cal_avg)
    end
    i_conv_busy = 1;
    tick(2);
    rd(m | 8'h80);
    i_conv_busy = 0;
    tick(2);
    rd(m);
    // a start at a foreign address must not land
    i_addr = ADCCAL_ADDR ^ 8'h01;
    wr(8'hB7);
    i_addr = ADCCAL_ADDR;
    rd(m);
    `CHK("req_other", 1'b0, o_cal_req)
    // reset in the middle of a run
    wr(8'h27);
    tick(2);
    i_rst = 1;
    tick(2);
    i_rst = 0;
    `CHK("gain_rst", 1'b0, o_cal_gain)
    `CHK("avg_rst", 6'h00, o_cal_avg)
    rd(8'h00);
    finish_test;
  end
  initial begin
    #100000;
    err_total++;
    finish_test;
  end
endmodule
